/* pkg/cra_consts.svh */
// Constants of the configuration register access protocol.
// Operation
// - Status resource id is register shifted plus 0x0C.
// - Status read and write move whole words.
// - Tile destination is tile id plus C20C.
// - Node destination is node id plus C30C.
// - Peripheral destination is node, peripheral, 02.
// - Word write: 192, reply id, reg16, data32, 1.
// - Word read: 193, reply id, reg16, 1.
// - Write reply is 3,1 or 4,1.
// - Word read reply is 3,data32,1 or 4,1.
// - Peripheral write: 36, id, reg8, size, bytes, 1.
// - Peripheral read: 37, id, reg8, size, 1.
// - Peripheral read reply is 3,bytes,1 or 4,1.
`ifndef CRA_CONSTS_SVH
`define CRA_CONSTS_SVH
`define CRA_TOK_WR 8'hC0
`define CRA_TOK_RD 8'hC1
`define CRA_TOK_PWR 8'h24
`define CRA_TOK_PRD 8'h25
`define CRA_TOK_END 8'h01
`define CRA_TOK_OK 8'h03
`define CRA_TOK_FAIL 8'h04
`define CRA_SFX_TILE 16'hC20C
`define CRA_SFX_NODE 16'hC30C
`define CRA_SFX_PER 8'h02
`define CRA_PS_TYPE 8'h0C
`define CRA_PS_SHIFT 8
`define CRA_WORDS 16
`define CRA_PBYTES 64
`define CRA_PMAX 8'h04
`endif

/* pkg/cra_pkg.sv */
// Types shared by both ends of the register access protocol.
`include "cra_consts.svh"
package cra_pkg;
  typedef enum logic [2:0] {
    CRA_TILE_WR,
    CRA_TILE_RD,
    CRA_NODE_WR,
    CRA_NODE_RD,
    CRA_PER_WR,
    CRA_PER_RD
  } cra_kind_t;

  typedef enum {
    CRA_HDR,
    CRA_RID,
    CRA_REG,
    CRA_SIZE,
    CRA_DATA,
    CRA_END,
    CRA_DRAIN,
    CRA_RESP
  } cra_dev_state_t;

  typedef enum {
    CRA_R_IDLE,
    CRA_R_SEND,
    CRA_R_WAIT
  } cra_req_state_t;

  // Builds the processor-status resource id from a register number.
  function automatic logic [31:0] cra_ps_rsrc(input logic [23:0] regn);
    cra_ps_rsrc = {regn, `CRA_PS_TYPE};
  endfunction
endpackage

/* pkg/cra_if.sv */
// Token link between a requesting channel-end and the register interpreter.
`timescale 1ns/1ps
interface cra_if;
  logic req_valid;
  logic req_ready;
  logic req_ctrl;
  logic [7:0] req_data;
  logic [31:0] req_dest;
  logic rsp_valid;
  logic rsp_ready;
  logic rsp_ctrl;
  logic [7:0] rsp_data;
  logic [23:0] rsp_dest;
  modport device(
    input req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
  modport requester(
    output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
endinterface

/* verilog/cra_device.sv */
// Configuration register interpreter: parses request messages and replies.
`timescale 1ns/1ps
`include "cra_consts.svh"
module cra_device #(
  parameter int WORDS = `CRA_WORDS,
  parameter int PBYTES = `CRA_PBYTES,
  parameter logic [15:0] TILE_ID = 16'h0001,
  parameter logic [15:0] NODE_ID = 16'h0002
) (
  input wire logic clk,
  input wire logic reset,
  cra_if.device link,
  input wire logic ps_valid,
  input wire logic ps_write,
  input wire logic [31:0] ps_rsrc,
  input wire logic [31:0] ps_wdata,
  output logic ps_done,
  output logic ps_ok,
  output logic [31:0] ps_rdata
);
  localparam int AW = $clog2(WORDS);
  localparam int PW = $clog2(PBYTES);

  cra_pkg::cra_dev_state_t state_reg;
  logic ready_reg;
  logic wr_reg;
  logic per_reg;
  logic node_reg;
  logic bad_reg;
  logic mute_reg;
  logic [23:0] rid_reg;
  logic [15:0] regn_reg;
  logic [7:0] size_reg;
  logic [7:0] cnt_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic [8:0] idx_reg;
  logic rsp_valid_reg;
  logic rsp_ctrl_reg;
  logic [7:0] rsp_data_reg;
  logic [23:0] rsp_dest_reg;
  logic [31:0] word_mem [3][WORDS];
  logic [7:0] byte_mem [PBYTES];

  logic take;
  logic is_end;
  logic known_hdr;
  logic commit;
  logic rsp_fin;
  logic rsp_slot;
  logic ps_hit;
  logic [15:0] regn_full;
  logic [8:0] rsp_len;
  logic [PW-1:0] rd_addr;

  // A register number outside the word banks makes the request fail.
  function automatic logic word_ok(input logic [15:0] n);
    word_ok = {16'h0000, n} < 32'(WORDS);
  endfunction

  // The destination must carry this interpreter's id and bank suffix.
  function automatic logic dest_ok(input logic per, input logic [31:0] d);
    if (per) begin
      dest_ok = d[31:16] == NODE_ID && d[7:0] == `CRA_SFX_PER;
    end else begin
      dest_ok = d == {TILE_ID, `CRA_SFX_TILE} || d == {NODE_ID, `CRA_SFX_NODE};
    end
  endfunction

  assign link.req_ready = ready_reg;
  assign link.rsp_valid = rsp_valid_reg;
  assign link.rsp_ctrl = rsp_ctrl_reg;
  assign link.rsp_data = rsp_data_reg;
  assign link.rsp_dest = rsp_dest_reg;

  assign take = link.req_valid && ready_reg;
  assign is_end = link.req_ctrl && link.req_data == `CRA_TOK_END;
  assign known_hdr = link.req_data == `CRA_TOK_WR || link.req_data == `CRA_TOK_RD ||
                     link.req_data == `CRA_TOK_PWR || link.req_data == `CRA_TOK_PRD;
  assign regn_full = per_reg ? {8'h00, link.req_data} : {regn_reg[7:0], link.req_data};
  assign commit = take && state_reg == cra_pkg::CRA_END && is_end && !bad_reg;
  assign rsp_slot = !rsp_valid_reg || link.rsp_ready;
  // Reply length counts the status token and the data tokens after it.
  assign rsp_len = (!bad_reg && !wr_reg) ?
                   ((per_reg ? {1'b0, size_reg} : 9'h004) + 9'h001) : 9'h001;
  assign rsp_fin = state_reg == cra_pkg::CRA_RESP && rsp_valid_reg && link.rsp_ready &&
                   idx_reg == rsp_len + 9'h001;
  assign rd_addr = regn_reg[PW-1:0] + PW'(idx_reg - 9'h001);
  assign ps_hit = ps_rsrc[7:0] == `CRA_PS_TYPE &&
                  {8'h00, ps_rsrc[31:`CRA_PS_SHIFT]} < 32'(WORDS);

  // Request parsing. Ready stays low for the whole reply, so a new request
  // cannot start until the previous one has been answered.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= cra_pkg::CRA_HDR;
      ready_reg <= 1'b1;
      wr_reg <= 1'b0;
      per_reg <= 1'b0;
      node_reg <= 1'b0;
      bad_reg <= 1'b0;
      mute_reg <= 1'b0;
      rid_reg <= 24'h000000;
      regn_reg <= 16'h0000;
      size_reg <= 8'h00;
      cnt_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
    end else if (take && link.req_ctrl && state_reg != cra_pkg::CRA_HDR &&
                 state_reg != cra_pkg::CRA_END && state_reg != cra_pkg::CRA_DRAIN) begin
      // A control token where payload belongs breaks the message.
      bad_reg <= 1'b1;
      state_reg <= is_end ? cra_pkg::CRA_RESP : cra_pkg::CRA_DRAIN;
      ready_reg <= !is_end;
    end else begin
      case (state_reg)
        cra_pkg::CRA_HDR: begin
          if (take && link.req_ctrl && !is_end) begin
            bad_reg <= 1'b0;
            cnt_reg <= 8'h02;
            wr_reg <= link.req_data == `CRA_TOK_WR || link.req_data == `CRA_TOK_PWR;
            per_reg <= link.req_data == `CRA_TOK_PWR || link.req_data == `CRA_TOK_PRD;
            node_reg <= link.req_dest[15:0] == `CRA_SFX_NODE;
            if (known_hdr) begin
              mute_reg <= 1'b0;
              bad_reg <= !dest_ok(link.req_data == `CRA_TOK_PWR ||
                                  link.req_data == `CRA_TOK_PRD, link.req_dest);
              state_reg <= cra_pkg::CRA_RID;
            end else begin
              // With no reply id yet, an unknown message is dropped silently.
              mute_reg <= 1'b1;
              state_reg <= cra_pkg::CRA_DRAIN;
            end
          end
        end
        cra_pkg::CRA_RID: begin
          if (take) begin
            rid_reg <= {rid_reg[15:0], link.req_data};
            cnt_reg <= per_reg ? 8'h00 : 8'h01;
            if (cnt_reg == 8'h00) begin
              state_reg <= cra_pkg::CRA_REG;
            end else begin
              cnt_reg <= cnt_reg - 8'h01;
            end
          end
        end
        cra_pkg::CRA_REG: begin
          if (take) begin
            regn_reg <= regn_full;
            if (cnt_reg != 8'h00) begin
              cnt_reg <= cnt_reg - 8'h01;
            end else if (per_reg) begin
              state_reg <= cra_pkg::CRA_SIZE;
            end else begin
              bad_reg <= bad_reg || !word_ok(regn_full);
              cnt_reg <= 8'h03;
              state_reg <= wr_reg ? cra_pkg::CRA_DATA : cra_pkg::CRA_END;
            end
          end
        end
        cra_pkg::CRA_SIZE: begin
          if (take) begin
            size_reg <= link.req_data;
            cnt_reg <= link.req_data - 8'h01;
            if (({8'h00, regn_reg[7:0]} + {8'h00, link.req_data}) > 16'(PBYTES)) begin
              bad_reg <= 1'b1;
            end
            if (wr_reg && link.req_data != 8'h00) begin
              state_reg <= cra_pkg::CRA_DATA;
            end else begin
              state_reg <= cra_pkg::CRA_END;
            end
          end
        end
        cra_pkg::CRA_DATA: begin
          if (take) begin
            wdata_reg <= {wdata_reg[23:0], link.req_data};
            if (per_reg) begin
              regn_reg <= regn_reg + 16'h0001;
            end
            if (cnt_reg == 8'h00) begin
              state_reg <= cra_pkg::CRA_END;
            end else begin
              cnt_reg <= cnt_reg - 8'h01;
            end
          end
        end
        cra_pkg::CRA_END: begin
          if (take && is_end) begin
            state_reg <= cra_pkg::CRA_RESP;
            ready_reg <= 1'b0;
          end else if (take) begin
            bad_reg <= 1'b1;
            state_reg <= cra_pkg::CRA_DRAIN;
          end
        end
        cra_pkg::CRA_DRAIN: begin
          if (take && is_end) begin
            state_reg <= mute_reg ? cra_pkg::CRA_HDR : cra_pkg::CRA_RESP;
            ready_reg <= mute_reg;
          end
        end
        cra_pkg::CRA_RESP: begin
          if (rsp_fin) begin
            state_reg <= cra_pkg::CRA_HDR;
            ready_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= cra_pkg::CRA_HDR;
          ready_reg <= 1'b1;
        end
      endcase
    end
  end

  // Register banks: tile, node and processor status words, then peripheral
  // bytes. Peripheral bytes land as they arrive, so a message that breaks
  // after its data has already changed them.
  always_ff @(posedge clk) begin
    if (commit && wr_reg && !per_reg) begin
      word_mem[{1'b0, node_reg}][regn_reg[AW-1:0]] <= wdata_reg;
    end
    if (ps_valid && ps_write && ps_hit) begin
      word_mem[2'h2][ps_rsrc[`CRA_PS_SHIFT +: AW]] <= ps_wdata;
    end
    if (take && state_reg == cra_pkg::CRA_DATA && !link.req_ctrl && per_reg && !bad_reg) begin
      byte_mem[regn_reg[PW-1:0]] <= link.req_data;
    end
  end

  // Reply emission. Tokens go out one at a time; the next is loaded only
  // when the slot is empty or the current one is being taken.
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid_reg <= 1'b0;
      rsp_ctrl_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      rsp_dest_reg <= 24'h000000;
      rdata_reg <= 32'h00000000;
      idx_reg <= 9'h000;
    end else begin
      if (commit && !wr_reg && !per_reg) begin
        rdata_reg <= word_mem[{1'b0, node_reg}][regn_reg[AW-1:0]];
      end
      if (rsp_fin) begin
        rsp_valid_reg <= 1'b0;
        idx_reg <= 9'h000;
      end else if (state_reg == cra_pkg::CRA_RESP && rsp_slot &&
                   idx_reg <= rsp_len) begin
        rsp_valid_reg <= 1'b1;
        rsp_dest_reg <= rid_reg;
        idx_reg <= idx_reg + 9'h001;
        if (idx_reg == 9'h000) begin
          rsp_ctrl_reg <= 1'b1;
          rsp_data_reg <= bad_reg ? `CRA_TOK_FAIL : `CRA_TOK_OK;
        end else if (idx_reg == rsp_len) begin
          rsp_ctrl_reg <= 1'b1;
          rsp_data_reg <= `CRA_TOK_END;
        end else if (per_reg) begin
          rsp_ctrl_reg <= 1'b0;
          rsp_data_reg <= byte_mem[rd_addr];
        end else begin
          rsp_ctrl_reg <= 1'b0;
          rsp_data_reg <= rdata_reg[31:24];
          rdata_reg <= {rdata_reg[23:0], 8'h00};
        end
      end
    end
  end

  // Processor-status port: one whole word per access, answered next cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      ps_done <= 1'b0;
      ps_ok <= 1'b0;
      ps_rdata <= 32'h00000000;
    end else begin
      ps_done <= ps_valid;
      ps_ok <= ps_valid && ps_hit;
      if (ps_valid && ps_hit && !ps_write) begin
        ps_rdata <= word_mem[2'h2][ps_rsrc[`CRA_PS_SHIFT +: AW]];
      end
    end
  end
endmodule // cra_device

/* verilog/cra_requester.sv */
// Requesting channel-end: sends one register message and collects its reply.
`timescale 1ns/1ps
`include "cra_consts.svh"
module cra_requester (
  input wire logic clk,
  input wire logic reset,
  cra_if.requester link,
  input wire logic cmd_valid,
  input wire cra_pkg::cra_kind_t cmd_kind,
  input wire logic [15:0] cmd_id,
  input wire logic [7:0] cmd_pid,
  input wire logic [15:0] cmd_reg,
  input wire logic [7:0] cmd_size,
  input wire logic [31:0] cmd_wdata,
  input wire logic [23:0] cmd_rid,
  output logic cmd_ready,
  output logic done,
  output logic done_ok,
  output logic [31:0] done_rdata
);
  cra_pkg::cra_req_state_t state_reg;
  logic req_valid_reg;
  logic req_ctrl_reg;
  logic [7:0] req_data_reg;
  logic [31:0] req_dest_reg;
  logic rsp_ready_reg;
  logic [23:0] rid_reg;
  logic [71:0] body_reg;
  logic [3:0] blen_reg;
  logic [3:0] idx_reg;
  logic per;
  logic wr;
  logic [7:0] psize;
  logic mine;

  assign link.req_valid = req_valid_reg;
  assign link.req_ctrl = req_ctrl_reg;
  assign link.req_data = req_data_reg;
  assign link.req_dest = req_dest_reg;
  assign link.rsp_ready = rsp_ready_reg;

  assign per = cmd_kind == cra_pkg::CRA_PER_WR || cmd_kind == cra_pkg::CRA_PER_RD;
  assign wr = cmd_kind == cra_pkg::CRA_TILE_WR || cmd_kind == cra_pkg::CRA_NODE_WR ||
              cmd_kind == cra_pkg::CRA_PER_WR;
  // Peripheral writes carry at most four bytes, taken from the top of the word.
  assign psize = (wr && cmd_size > `CRA_PMAX) ? `CRA_PMAX : cmd_size;
  assign mine = link.rsp_valid && rsp_ready_reg && link.rsp_dest == rid_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= cra_pkg::CRA_R_IDLE;
      cmd_ready <= 1'b1;
      req_valid_reg <= 1'b0;
      req_ctrl_reg <= 1'b0;
      req_data_reg <= 8'h00;
      req_dest_reg <= 32'h00000000;
      rsp_ready_reg <= 1'b0;
      rid_reg <= 24'h000000;
      body_reg <= 72'h0;
      blen_reg <= 4'h0;
      idx_reg <= 4'h0;
    end else begin
      case (state_reg)
        cra_pkg::CRA_R_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            rid_reg <= cmd_rid;
            req_valid_reg <= 1'b1;
            req_ctrl_reg <= 1'b1;
            // The index counts every taken token, header included, so the header takes slot zero.
            idx_reg <= 4'h0;
            state_reg <= cra_pkg::CRA_R_SEND;
            if (per) begin
              req_data_reg <= wr ? `CRA_TOK_PWR : `CRA_TOK_PRD;
              req_dest_reg <= {cmd_id, cmd_pid, `CRA_SFX_PER};
              body_reg <= {cmd_rid, cmd_reg[7:0], psize, cmd_wdata};
              blen_reg <= wr ? 4'h5 + psize[3:0] : 4'h5;
            end else begin
              req_data_reg <= wr ? `CRA_TOK_WR : `CRA_TOK_RD;
              if (cmd_kind == cra_pkg::CRA_NODE_WR || cmd_kind == cra_pkg::CRA_NODE_RD) begin
                req_dest_reg <= {cmd_id, `CRA_SFX_NODE};
              end else begin
                req_dest_reg <= {cmd_id, `CRA_SFX_TILE};
              end
              body_reg <= {cmd_rid, cmd_reg, cmd_wdata};
              blen_reg <= wr ? 4'h9 : 4'h5;
            end
          end
        end
        cra_pkg::CRA_R_SEND: begin
          if (link.req_ready) begin
            idx_reg <= idx_reg + 4'h1;
            if (idx_reg == blen_reg + 4'h1) begin
              req_valid_reg <= 1'b0;
              rsp_ready_reg <= 1'b1;
              state_reg <= cra_pkg::CRA_R_WAIT;
            end else if (idx_reg == blen_reg) begin
              req_ctrl_reg <= 1'b1;
              req_data_reg <= `CRA_TOK_END;
            end else begin
              req_ctrl_reg <= 1'b0;
              req_data_reg <= body_reg[71:64];
              body_reg <= {body_reg[63:0], 8'h00};
            end
          end
        end
        cra_pkg::CRA_R_WAIT: begin
          if (mine && link.rsp_ctrl && link.rsp_data == `CRA_TOK_END) begin
            rsp_ready_reg <= 1'b0;
            cmd_ready <= 1'b1;
            state_reg <= cra_pkg::CRA_R_IDLE;
          end
        end
        default: begin
          state_reg <= cra_pkg::CRA_R_IDLE;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end

  // Reply collection; tokens addressed to any other channel-end are dropped.
  always_ff @(posedge clk) begin
    if (reset) begin
      done <= 1'b0;
      done_ok <= 1'b0;
      done_rdata <= 32'h00000000;
    end else begin
      done <= 1'b0;
      if (state_reg == cra_pkg::CRA_R_IDLE && cmd_valid && cmd_ready) begin
        done_ok <= 1'b0;
        done_rdata <= 32'h00000000;
      end else if (mine && link.rsp_ctrl) begin
        if (link.rsp_data == `CRA_TOK_OK) begin
          done_ok <= 1'b1;
        end
        if (link.rsp_data == `CRA_TOK_FAIL) begin
          done_ok <= 1'b0;
        end
        if (link.rsp_data == `CRA_TOK_END && state_reg == cra_pkg::CRA_R_WAIT) begin
          done <= 1'b1;
        end
      end else if (mine) begin
        done_rdata <= {done_rdata[23:0], link.rsp_data};
      end
    end
  end
endmodule // cra_requester

/* tb/cra_link_sva.sv */
// Concurrent checks on the token link between requester and interpreter.
`timescale 1ns/1ps
`include "cra_consts.svh"
module cra_link_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic [31:0] req_dest,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data,
  input wire logic [23:0] rsp_dest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] hdr_reg;
  logic [7:0] rcnt_reg;
  logic [23:0] rid_reg;
  logic [7:0] size_reg;
  logic [7:0] dcnt_reg;
  logic st_reg;
  logic ok_reg;
  logic fail_reg;
  wire logic req_take = req_valid && req_ready;
  wire logic rsp_take = rsp_valid && rsp_ready;
  wire logic req_end = req_take && req_ctrl && req_data == `CRA_TOK_END;
  wire logic rsp_end = rsp_take && rsp_ctrl && rsp_data == `CRA_TOK_END;

  function automatic logic [7:0] req_len(input logic [7:0] h, input logic [7:0] s);
    case (h)
      `CRA_TOK_WR: req_len = 8'h09;
      `CRA_TOK_PWR: req_len = 8'h05 + s;
      default: req_len = 8'h05;
    endcase
  endfunction

  function automatic logic [7:0] rsp_len(input logic [7:0] h, input logic [7:0] s);
    case (h)
      `CRA_TOK_RD: rsp_len = 8'h04;
      `CRA_TOK_PRD: rsp_len = s;
      default: rsp_len = 8'h00;
    endcase
  endfunction

  // Only whole messages are sent here, so any control token but the closer is a header.
  always_ff @(posedge clk) begin
    if (reset) begin
      hdr_reg <= 8'h00;
      rcnt_reg <= 8'h00;
    end else if (req_take && req_ctrl && !req_end) begin
      hdr_reg <= req_data;
      rcnt_reg <= 8'h00;
    end else if (req_take && !req_ctrl) begin
      rcnt_reg <= rcnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (req_take && !req_ctrl && rcnt_reg < 8'h03) begin
      rid_reg <= {rid_reg[15:0], req_data};
    end
    if (req_take && !req_ctrl && rcnt_reg == 8'h04) begin
      size_reg <= req_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= 1'b1;
      ok_reg <= 1'b0;
      fail_reg <= 1'b0;
      dcnt_reg <= 8'h00;
    end else if (rsp_take) begin
      st_reg <= rsp_end;
      ok_reg <= st_reg ? rsp_data == `CRA_TOK_OK : ok_reg;
      fail_reg <= st_reg && rsp_data == `CRA_TOK_FAIL;
      dcnt_reg <= st_reg ? 8'h00 : dcnt_reg + {7'h00, !rsp_ctrl};
    end
  end

  AST_REQ_HOLD: assert property (req_valid && !req_ready |=> req_valid && $stable(req_ctrl)
    && $stable(req_data) && $stable(req_dest))
    else $error("request token changed before it was taken");
  AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid
    && $stable({rsp_ctrl, rsp_data, rsp_dest}))
    else $error("reply token changed before it was taken");
  AST_STATUS_TOKEN: assert property (rsp_valid && st_reg |-> rsp_ctrl
    && (rsp_data == `CRA_TOK_OK || rsp_data == `CRA_TOK_FAIL))
    else $error("reply does not open with a status token");
  AST_FAIL_CLOSE: assert property (rsp_take && fail_reg |-> rsp_end)
    else $error("failure token not followed by the closing token");
  AST_REPLY_TIME: assert property (req_end |-> ##[1:3] rsp_valid && st_reg)
    else $error("no reply started after the closing request token");
  AST_BUSY: assert property (rsp_valid |-> !req_ready)
    else $error("request taken while a reply is pending");
  AST_RSP_DEST: assert property (rsp_valid |-> rsp_dest == rid_reg)
    else $error("reply not sent to the carried channel-end");
  AST_REQ_LEN: assert property (req_end |-> rcnt_reg == req_len(hdr_reg, size_reg))
    else $error("request payload length wrong for its header");
  AST_REPLY_LEN: assert property (rsp_end && ok_reg && !st_reg
    |-> dcnt_reg == rsp_len(hdr_reg, size_reg))
    else $error("reply data length wrong for the request");

  cover property (rsp_take && st_reg && rsp_data == `CRA_TOK_FAIL);
  cover property (rsp_end && ok_reg && hdr_reg == `CRA_TOK_RD);
  cover property (rsp_end && ok_reg && hdr_reg == `CRA_TOK_PRD);
endmodule // cra_link_sva

/* tb/config_register_access_protocol_bench.sv */
// Testbench joining the requester and the interpreter over the token link.
`timescale 1ns/1ps
module config_register_access_protocol_bench;
  localparam logic [15:0] TID = 16'h0001;
  localparam logic [15:0] NID = 16'h0002;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  cra_pkg::cra_kind_t cmd_kind = cra_pkg::CRA_TILE_RD;
  logic [15:0] cmd_id = 16'h0000;
  logic [7:0] cmd_pid = 8'h05;
  logic [15:0] cmd_reg = 16'h0000;
  logic [7:0] cmd_size = 8'h00;
  logic [31:0] cmd_wdata = 32'h0;
  logic [23:0] cmd_rid = 24'h000010;
  logic ps_valid = 1'b0;
  logic ps_write = 1'b0;
  logic [31:0] ps_rsrc = 32'h0;
  logic [31:0] ps_wdata = 32'h0;
  logic cmd_ready, done, done_ok, ps_done, ps_ok;
  logic [31:0] done_rdata, ps_rdata;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  cra_if cra_if_inst();
  cra_device #(.WORDS(16), .PBYTES(64), .TILE_ID(TID), .NODE_ID(NID)) cra_device_inst (
    .clk(clk), .reset(reset), .link(cra_if_inst), .ps_valid(ps_valid), .ps_write(ps_write),
    .ps_rsrc(ps_rsrc), .ps_wdata(ps_wdata), .ps_done(ps_done), .ps_ok(ps_ok),
    .ps_rdata(ps_rdata));
  cra_requester cra_requester_inst (
    .clk(clk), .reset(reset), .link(cra_if_inst), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_id(cmd_id), .cmd_pid(cmd_pid), .cmd_reg(cmd_reg), .cmd_size(cmd_size),
    .cmd_wdata(cmd_wdata), .cmd_rid(cmd_rid), .cmd_ready(cmd_ready), .done(done),
    .done_ok(done_ok), .done_rdata(done_rdata));
  cra_link_sva cra_link_sva_inst (
    .clk(clk), .reset(reset), .req_valid(cra_if_inst.req_valid),
    .req_ready(cra_if_inst.req_ready), .req_ctrl(cra_if_inst.req_ctrl),
    .req_data(cra_if_inst.req_data), .req_dest(cra_if_inst.req_dest),
    .rsp_valid(cra_if_inst.rsp_valid), .rsp_ready(cra_if_inst.rsp_ready),
    .rsp_ctrl(cra_if_inst.rsp_ctrl), .rsp_data(cra_if_inst.rsp_data),
    .rsp_dest(cra_if_inst.rsp_dest));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Each command gets a fresh reply id so a misrouted reply cannot pass.
  task automatic run_cmd(input cra_pkg::cra_kind_t k, input logic [15:0] id,
      input logic [15:0] rg, input logic [7:0] sz, input logic [31:0] wd, input logic eok,
      input logic [31:0] mask, input logic [31:0] ed);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_id <= id;
    cmd_reg <= rg;
    cmd_size <= sz;
    cmd_wdata <= wd;
    cmd_rid <= cmd_rid + 24'h010203;
    @(negedge clk);
    for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge clk);
    check({31'h0, done}, 32'h1);
    check({31'h0, cmd_ready}, 32'h1);
    check({31'h0, done_ok}, {31'h0, eok});
    check(done_rdata & mask, ed);
  endtask

  task automatic ps_acc(input logic wr, input logic [31:0] rs, input logic [31:0] wd,
      input logic eok, input logic [31:0] ed);
    @(posedge clk);
    ps_valid <= 1'b1;
    ps_write <= wr;
    ps_rsrc <= rs;
    ps_wdata <= wd;
    @(posedge clk);
    ps_valid <= 1'b0;
    @(negedge clk);
    check({31'h0, ps_done}, 32'h1);
    check({31'h0, ps_ok}, {31'h0, eok});
    check(ps_rdata & {32{!wr && eok}}, ed);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    run_cmd(cra_pkg::CRA_TILE_WR, TID, 16'h000F, 8'h00, 32'hA5C30F1E, 1'b1, 0, 0);
    run_cmd(cra_pkg::CRA_NODE_WR, NID, 16'h000F, 8'h00, 32'h5A3CF0E1, 1'b1, 0, 0);
    run_cmd(cra_pkg::CRA_TILE_RD, TID, 16'h000F, 8'h00, 0, 1'b1, '1, 32'hA5C30F1E);
    run_cmd(cra_pkg::CRA_NODE_RD, NID, 16'h000F, 8'h00, 0, 1'b1, '1, 32'h5A3CF0E1);
    run_cmd(cra_pkg::CRA_TILE_WR, TID, 16'h0010, 8'h00, 32'h1, 1'b0, 0, 0);
    run_cmd(cra_pkg::CRA_NODE_RD, NID, 16'h0010, 8'h00, 0, 1'b0, 0, 0);
    run_cmd(cra_pkg::CRA_TILE_RD, 16'h0009, 16'h000F, 8'h00, 0, 1'b0, 0, 0);
    run_cmd(cra_pkg::CRA_PER_WR, NID, 16'h0008, 8'h04, 32'h11223344, 1'b1, 0, 0);
    run_cmd(cra_pkg::CRA_PER_RD, NID, 16'h0009, 8'h02, 0, 1'b1, 32'hFFFF, 32'h2233);
    run_cmd(cra_pkg::CRA_PER_RD, NID, 16'h0008, 8'h04, 0, 1'b1, '1, 32'h11223344);
    run_cmd(cra_pkg::CRA_PER_RD, NID, 16'h003E, 8'h04, 0, 1'b0, 0, 0);
    run_cmd(cra_pkg::CRA_PER_WR, 16'h0009, 16'h0008, 8'h01, 32'h0, 1'b0, 0, 0);
    ps_acc(1'b1, 32'h0000050C, 32'h1234ABCD, 1'b1, 32'h0);
    ps_acc(1'b0, 32'h0000050C, 32'h0, 1'b1, 32'h1234ABCD);
    ps_acc(1'b0, 32'h0000050D, 32'h0, 1'b0, 32'h0);
    ps_acc(1'b1, 32'h0000100C, 32'h1, 1'b0, 32'h0);
    final_report();
  end
endmodule // config_register_access_protocol_bench
